// [hdl/lsag_addr_gen.sv]
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "lsag_defines.svh"
module lsag_addr_gen (
    input wire logic sys_clk,
    input wire logic reset,
    input wire lsag_pkg::lsag_req_s req,
    output lsag_pkg::lsag_res_s res,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import lsag_pkg::*;

    lsag_state_s s;
    lsag_state_s n;

    ////////////////////////////////////////////////////////////////////////////
    // Operand fields
    logic [31:0] off_short;
    logic [31:0] off_long;
    logic [31:0] abs_addr;
    logic [31:0] sum_short;
    logic [31:0] sum_long;
    logic [15:0] idx;
    logic [15:0] len;
    logic [15:0] modif;
    logic [4:0] sz_bytes;

    // Sign extension of the instruction offsets
    assign off_short = {{22{req.imm[9]}}, req.imm[9:0]};
    assign off_long = {{16{req.imm[15]}}, req.imm[15:0]};
    // Constant top bits go to the segment field, the gap stays zero
    assign abs_addr = {req.imm[17:14], 14'h0000, req.imm[13:0]}; // RULE1 RULE2
    assign sum_short = req.base + off_short; // RULE3
    assign sum_long = req.base + off_long; // RULE4
    // Odd register holds the upper and lower halves of pair state
    assign idx = req.pair[15:0]; // RULE7 RULE14
    assign len = req.pair[31:16]; // RULE7
    assign modif = req.pair[31:16]; // RULE14
    assign sz_bytes = 5'h01 << req.size;

    ////////////////////////////////////////////////////////////////////////////
    // Circular buffer arithmetic
    logic [17:0] circ_raw;
    logic circ_neg;
    logic circ_over;
    logic [17:0] circ_fix;
    logic [31:0] circ_addr;
    logic [16:0] circ_end;
    logic circ_split;
    logic [15:0] circ_first;
    logic circ_misalign;

    // Raw index step by the signed byte offset
    assign circ_raw = {2'h0, idx} + {{8{req.imm[9]}}, req.imm[9:0]}; // RULE8
    assign circ_neg = circ_raw[17];
    assign circ_over = !circ_neg && (circ_raw >= {2'h0, len});
    // Wrap back into the buffer on either side
    always_comb begin
        if (circ_neg) begin
            circ_fix = circ_raw + {2'h0, len}; // RULE9
        end else if (circ_over) begin
            circ_fix = circ_raw - {2'h0, len}; // RULE9
        end else begin
            circ_fix = circ_raw;
        end
    end
    assign circ_addr = req.base + {16'h0000, idx}; // RULE7
    // An access running past the end continues at the base
    assign circ_end = {1'b0, idx} + {12'h000, sz_bytes};
    assign circ_split = circ_end > {1'b0, len}; // RULE10
    assign circ_first = len - idx;
    // Base alignment, length granularity and index range checks
    assign circ_misalign = ((req.base & `LSAG_BASE_ALIGN_MASK) != 32'h0) // RULE11
        || ((len & ({11'h000, sz_bytes} - 16'h0001)) != 16'h0000) // RULE12
        || (idx >= len); // RULE13

    ////////////////////////////////////////////////////////////////////////////
    // Bit-reverse index update
    logic [15:0] rev_idx;
    logic [15:0] rev_mod;
    logic [15:0] rev_sum;
    logic [15:0] brev_next;
    logic [31:0] brev_addr;

    lsag_bit_reverse #(.W(`LSAG_HALF_W)) u_rev_idx (
        .din(idx),
        .dout(rev_idx)
    );
    lsag_bit_reverse #(.W(`LSAG_HALF_W)) u_rev_mod (
        .din(modif),
        .dout(rev_mod)
    );
    // Add in mirrored space so the carry runs toward the low bits
    assign rev_sum = rev_idx + rev_mod; // RULE15
    lsag_bit_reverse #(.W(`LSAG_HALF_W)) u_rev_sum (
        .din(rev_sum),
        .dout(brev_next)
    );
    assign brev_addr = req.base + {16'h0000, idx}; // RULE14

    ////////////////////////////////////////////////////////////////////////////
    // Index helper operations
    logic [31:0] scaled_sum;
    logic [31:0] bitidx_sum;

    assign scaled_sum = req.base + (req.data << req.scale); // RULE17
    assign bitidx_sum = (req.base + (req.data >> `LSAG_BITIDX_SHIFT))
        & `LSAG_WORD_MASK; // RULE18

    // Segment field differs between two addresses
    function automatic logic seg_cross(input logic [31:0] a, input logic [31:0] b);
        seg_cross = a[`LSAG_SEG_HI:`LSAG_SEG_LO] != b[`LSAG_SEG_HI:`LSAG_SEG_LO]; // RULE20
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    logic [1:0] stat_clr;
    logic [1:0] stat_set;
    logic [9:0] ridx;

    assign ridx = araddr[11:2];

    always_comb begin
        n = s;
        n.res = '0;
        stat_clr = 2'h0;
        stat_set = 2'h0;

        // Write channel capture, either order
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (awvalid && s.awready) begin
            n.aw_got = 1'b1;
            n.aw_addr = awaddr;
        end
        if (wvalid && s.wready) begin
            n.w_got = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        // Register write once both halves are in and the response is free
        // Decode the address just captured, it may arrive in this very cycle
        if (n.aw_got && n.w_got && !n.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `LSAG_RESP_OKAY;
            if (n.aw_addr[11:2] == `LSAG_CTRL_OFFS >> 2) begin
                if (n.wstrb[0]) begin
                    n.enable = n.wdata[`LSAG_CTRL_ENABLE_BIT];
                end
            end else if (n.aw_addr[11:2] == `LSAG_STATUS_OFFS >> 2) begin
                if (n.wstrb[0]) begin
                    stat_clr = n.wdata[1:0];
                end
            end else if (n.aw_addr[11:2] > `LSAG_TRAP_COUNT_OFFS >> 2) begin
                n.bresp = `LSAG_RESP_SLVERR;
            end
        end
        n.awready = !n.aw_got;
        n.wready = !n.w_got;

        // Read channel
        if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp = `LSAG_RESP_OKAY;
            n.rdata = 32'h0000_0000;
            unique case (ridx)
                `LSAG_CTRL_OFFS >> 2: n.rdata = {31'h0000_0000, s.enable};
                `LSAG_STATUS_OFFS >> 2: n.rdata = {30'h0000_0000, s.status};
                `LSAG_COUNT_OFFS >> 2: n.rdata = s.count;
                `LSAG_LAST_ADDR_OFFS >> 2: n.rdata = s.last_addr;
                `LSAG_TRAP_ADDR_OFFS >> 2: n.rdata = s.trap_addr;
                `LSAG_TRAP_COUNT_OFFS >> 2: n.rdata = s.trap_count;
                default: n.rresp = `LSAG_RESP_SLVERR;
            endcase
        end
        n.arready = !n.rvalid;

        // Address generation, one request per cycle
        if (req.valid && s.enable) begin
            n.res.valid = 1'b1;
            unique case (req.op)
                LSAG_OP_ABS: begin
                    n.res.access = 1'b1;
                    n.res.addr = abs_addr; // RULE1
                end
                LSAG_OP_BSO: begin
                    n.res.access = 1'b1;
                    n.res.addr = sum_short; // RULE3
                    n.res.mem_trap = seg_cross(sum_short, req.base); // RULE21
                end
                LSAG_OP_BLO: begin
                    n.res.access = 1'b1;
                    n.res.addr = sum_long; // RULE4
                    n.res.mem_trap = seg_cross(sum_long, req.base); // RULE21
                end
                LSAG_OP_PRE: begin
                    n.res.access = 1'b1;
                    n.res.addr = sum_short; // RULE5
                    n.res.wb_en = 1'b1;
                    n.res.wb_val = sum_short; // RULE5
                    n.res.mem_trap = seg_cross(sum_short, req.base); // RULE21
                end
                LSAG_OP_POST: begin
                    n.res.access = 1'b1;
                    n.res.addr = req.base; // RULE6
                    n.res.wb_en = 1'b1;
                    n.res.wb_val = sum_short; // RULE6
                end
                LSAG_OP_CIRC: begin
                    n.res.access = 1'b1;
                    n.res.addr = circ_addr; // RULE7
                    n.res.split = circ_split; // RULE10
                    n.res.first_bytes = circ_split ? circ_first[3:0] : sz_bytes[3:0];
                    n.res.split_addr = req.base; // RULE10
                    n.res.pair_wb_en = 1'b1;
                    n.res.pair_val = {len, circ_fix[15:0]}; // RULE8
                    n.res.alignment_trap = circ_misalign; // RULE11 RULE12 RULE13
                    n.res.mem_trap = seg_cross(circ_addr, req.base); // RULE21
                end
                LSAG_OP_BREV: begin
                    n.res.access = 1'b1;
                    n.res.addr = brev_addr; // RULE14
                    n.res.pair_wb_en = 1'b1;
                    n.res.pair_val = {modif, brev_next}; // RULE15
                    n.res.mem_trap = seg_cross(brev_addr, req.base); // RULE21
                end
                LSAG_OP_SCALED: begin
                    n.res.wb_en = 1'b1;
                    n.res.wb_val = scaled_sum; // RULE17
                end
                LSAG_OP_BITIDX: begin
                    n.res.wb_en = 1'b1;
                    n.res.wb_val = bitidx_sum; // RULE18
                end
                LSAG_OP_LINK: begin
                    n.res.link_we = 1'b1;
                    n.res.link_val = req.next_pc; // RULE19
                end
                default: begin
                    n.res.valid = 1'b0;
                end
            endcase
            // A trap replaces the access and all register updates
            if (n.res.alignment_trap || n.res.mem_trap) begin
                n.res.access = 1'b0; // RULE21
                n.res.split = 1'b0;
                n.res.wb_en = 1'b0;
                n.res.pair_wb_en = 1'b0;
                n.trap_addr = n.res.addr;
                n.trap_count = s.trap_count + 32'h0000_0001;
            end
            if (n.res.access) begin
                n.count = s.count + 32'h0000_0001;
                n.last_addr = n.res.addr;
            end
            stat_set[`LSAG_STAT_ALIGN_BIT] = n.res.alignment_trap;
            stat_set[`LSAG_STAT_MEM_BIT] = n.res.mem_trap;
        end

        // Sticky trap flags, a new trap beats a clear in the same cycle
        n.status = (s.status & ~stat_clr) | stat_set;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s <= '0;
            s.enable <= `LSAG_CTRL_RESET;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state register
    assign res = s.res;
    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
endmodule

// [hdl/lsag_defines.svh]
`ifndef LSAG_DEFINES_SVH
`define LSAG_DEFINES_SVH
// What this block does
// RULE1: Absolute: constant top 4 bits to address top
// RULE2: Absolute: low 14 bits kept, 27:14 zero
// RULE3: Short offset: register plus sign-extended 10 bits
// RULE4: Long offset: register plus sign-extended 16 bits
// RULE5: Pre-update: sum is address and write-back
// RULE6: Post-update: access register, write back sum
// RULE7: Circular: even base, odd length and index
// RULE8: Circular index post-update wraps inside buffer
// RULE9: Wrap subtracts length if over, adds if negative
// RULE10: Access past buffer end wraps to start
// RULE11: Circular base must be 64-bit aligned
// RULE12: Buffer length multiple of access size
// RULE13: Alignment trap when index not below length
// RULE14: Bit-reverse: even base, odd index and modifier
// RULE15: Index becomes reverse of reversed sums
// RULE16: Software sets modifier to half buffer size
// RULE17: Scaled add: address plus data times 1,2,4,8
// RULE18: Bit add: data shifted right 3, low bits cleared
// RULE19: Jump with link writes next instruction address
// RULE20: Segment is the top 4 address bits
// RULE21: Segment crossing raises memory trap, no access

// Register byte offsets on the bus
`define LSAG_CTRL_OFFS 12'h000
`define LSAG_STATUS_OFFS 12'h004
`define LSAG_COUNT_OFFS 12'h008
`define LSAG_LAST_ADDR_OFFS 12'h00c
`define LSAG_TRAP_ADDR_OFFS 12'h010
`define LSAG_TRAP_COUNT_OFFS 12'h014
// Control and status fields
`define LSAG_CTRL_ENABLE_BIT 0
`define LSAG_CTRL_RESET 1'h1
`define LSAG_STAT_ALIGN_BIT 0
`define LSAG_STAT_MEM_BIT 1
// Bus responses
`define LSAG_RESP_OKAY 2'h0
`define LSAG_RESP_SLVERR 2'h2
// Address layout
`define LSAG_SEG_HI 31
`define LSAG_SEG_LO 28
`define LSAG_ABS_LOW_BITS 14
`define LSAG_BASE_ALIGN_MASK 32'h0000_0007
`define LSAG_WORD_MASK 32'hffff_fffc
`define LSAG_BITIDX_SHIFT 3
`define LSAG_HALF_W 16
`endif

// [hdl/lsag_pkg.sv]
package lsag_pkg;

    // Operation requested by decode
    typedef enum logic [3:0] {
        LSAG_OP_ABS, LSAG_OP_BSO, LSAG_OP_BLO, LSAG_OP_PRE, LSAG_OP_POST,
        LSAG_OP_CIRC, LSAG_OP_BREV, LSAG_OP_SCALED, LSAG_OP_BITIDX, LSAG_OP_LINK
    } lsag_op_e;

    // Access size, code equals log2 of the byte count
    typedef enum logic [1:0] {
        LSAG_SZ_BYTE, LSAG_SZ_HALF, LSAG_SZ_WORD, LSAG_SZ_DWORD
    } lsag_size_e;

    // Request from decode and the address register file
    typedef struct packed {
        logic valid;
        lsag_op_e op;
        lsag_size_e size;
        logic [17:0] imm;
        logic [31:0] base;
        logic [31:0] pair;
        logic [31:0] data;
        logic [1:0] scale;
        logic [31:0] next_pc;
    } lsag_req_s;

    // Result towards memory pipeline and register file
    typedef struct packed {
        logic valid;
        logic access;
        logic [31:0] addr;
        logic split;
        logic [3:0] first_bytes;
        logic [31:0] split_addr;
        logic wb_en;
        logic [31:0] wb_val;
        logic pair_wb_en;
        logic [31:0] pair_val;
        logic link_we;
        logic [31:0] link_val;
        logic alignment_trap;
        logic mem_trap;
    } lsag_res_s;

    // Whole state of the generator
    typedef struct packed {
        lsag_res_s res;
        logic enable;
        logic [1:0] status;
        logic [31:0] count;
        logic [31:0] last_addr;
        logic [31:0] trap_addr;
        logic [31:0] trap_count;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [11:0] aw_addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lsag_state_s;

endpackage

// [hdl/lsag_bit_reverse.sv]
`timescale 1ns/10ps
// Mirrors a vector: bit n swaps with bit W-1-n
module lsag_bit_reverse #(
    parameter int W = 16
) (
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // Pure wiring, no logic depth
    always_comb begin
        for (int i = 0; i < W; i++) begin
            dout[i] = din[W-1-i];
        end
    end
endmodule

// [dv/lsag_addr_gen_checker.sv]
`timescale 1ns/10ps
module lsag_addr_gen_checker (
    input wire logic sys_clk,
    input wire logic reset,
    input wire lsag_pkg::lsag_req_s req,
    input wire lsag_pkg::lsag_res_s res
);
    import lsag_pkg::*;
    lsag_req_s q;
    logic [31:0] s10;
    logic [31:0] s16;
    // Request that launched the current result
    always_ff @(posedge sys_clk) begin
        q <= req;
    end
    // Base plus sign-extended offsets
    assign s10 = q.base + {{22{q.imm[9]}}, q.imm[9:0]};
    assign s16 = q.base + {{16{q.imm[15]}}, q.imm[15:0]};
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    property p_abs;
        res.access && q.op == LSAG_OP_ABS |-> res.addr == {q.imm[17:14], 14'h0000, q.imm[13:0]};
    endproperty
    a_abs: assert property (p_abs) else $error("absolute address wrong");
    property p_bso;
        res.access && q.op == LSAG_OP_BSO |-> res.addr == s10;
    endproperty
    a_bso: assert property (p_bso) else $error("short offset address wrong");
    property p_blo;
        res.access && q.op == LSAG_OP_BLO |-> res.addr == s16;
    endproperty
    a_blo: assert property (p_blo) else $error("long offset address wrong");
    property p_pre;
        res.access && q.op == LSAG_OP_PRE |-> res.wb_en && res.addr == s10 && res.wb_val == s10;
    endproperty
    a_pre: assert property (p_pre) else $error("pre-update wrong");
    property p_post;
        res.access && q.op == LSAG_OP_POST |-> res.addr == q.base && res.wb_val == s10;
    endproperty
    a_post: assert property (p_post) else $error("post-update wrong");
    property p_scaled;
        res.valid && q.op == LSAG_OP_SCALED |-> res.wb_val == q.base + (q.data << q.scale);
    endproperty
    a_scaled: assert property (p_scaled) else $error("scaled add wrong");
    property p_bitidx;
        res.valid && q.op == LSAG_OP_BITIDX
            |-> res.wb_val == ((q.base + (q.data >> 3)) & 32'hffff_fffc);
    endproperty
    a_bitidx: assert property (p_bitidx) else $error("bit index add wrong");
    property p_link;
        res.valid && q.op == LSAG_OP_LINK |-> res.link_we && res.link_val == q.next_pc;
    endproperty
    a_link: assert property (p_link) else $error("link value wrong");
    property p_seg;
        res.valid && q.op == LSAG_OP_BSO && s10[31:28] != q.base[31:28]
            |-> res.mem_trap && !res.access;
    endproperty
    a_seg: assert property (p_seg) else $error("segment crossing not trapped");
    property p_circ_trap;
        res.valid && q.op == LSAG_OP_CIRC && q.pair[15:0] >= q.pair[31:16] |-> res.alignment_trap;
    endproperty
    a_circ_trap: assert property (p_circ_trap) else $error("index past length");
    property p_circ_addr;
        res.access && q.op == LSAG_OP_CIRC |-> res.addr == q.base + {16'h0000, q.pair[15:0]};
    endproperty
    a_circ_addr: assert property (p_circ_addr) else $error("circular address wrong");
endmodule
bind lsag_addr_gen lsag_addr_gen_checker lsag_addr_gen_checker_inst (
    .sys_clk(sys_clk),
    .reset(reset),
    .req(req),
    .res(res)
);

// [dv/lsag_regfile_model.sv]
`timescale 1ns/10ps
module lsag_regfile_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire lsag_pkg::lsag_res_s res,
    output logic [31:0] base_q,
    output logic [31:0] pair_q
);
    import lsag_pkg::*;
    // Address register pair, loaded for a bit-reversed walk and updated by write-back
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            base_q <= 32'h0000_4000;
            pair_q <= 32'h0400_0000;
        end else begin
            if (res.wb_en) base_q <= res.wb_val;
            if (res.pair_wb_en) pair_q <= res.pair_val;
        end
    end
endmodule

// [dv/load_store_address_generator_bench.sv]
`timescale 1ns/10ps
module load_store_address_generator_bench;
    import lsag_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    lsag_req_s req = '0;
    lsag_res_s res, got;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rd, rdata, base_q, pair_q;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, resp;
    logic awready, wready, bvalid, arready, rvalid;
    integer error_cnt = 0, n_checks = 0, seed = 32690;
    logic [15:0] idx_tbl [4] = '{16'h0000, 16'h0400, 16'h0200, 16'h0600};
    logic exp_en = 1'b1; // Enable bit as software last wrote it

    // Clock
    always #20 sys_clk = ~sys_clk;

    lsag_addr_gen lsag_addr_gen_inst (.sys_clk, .reset, .req, .res, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready);
    lsag_regfile_model lsag_regfile_model_inst (.sys_clk, .reset, .res, .base_q, .pair_q);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict;
        $display("TB: checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Bus write: both channels offered, each released once taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge sys_clk);
            ta = ta | (awready === 1'b1);
            tw = tw | (wready === 1'b1);
            @(posedge sys_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        do @(negedge sys_clk); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge sys_clk);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge sys_clk); while (arready !== 1'b1);
        @(posedge sys_clk);
        arvalid <= 1'b0;
        do @(negedge sys_clk); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        @(posedge sys_clk);
        rready <= 1'b0;
    endtask

    function automatic logic [15:0] rev(input logic [15:0] v);
        for (int i = 0; i < 16; i++) rev[i] = v[15 - i];
    endfunction

    // Expected result of one request
    function automatic lsag_res_s exp_of(input lsag_req_s r);
        lsag_res_s e;
        logic [31:0] s10, a, ln, ix, nb;
        integer raw;
        e = '0;
        // A disabled generator drops the request and shows nothing
        if (!exp_en) return e;
        s10 = {{22{r.imm[9]}}, r.imm[9:0]};
        ln = {16'h0000, r.pair[31:16]};
        ix = {16'h0000, r.pair[15:0]};
        nb = 32'h1 << r.size;
        a = r.base + s10;
        raw = int'(ix) + int'($signed(s10));
        if (raw < 0) raw += int'(ln);
        else if (raw >= int'(ln)) raw -= int'(ln);
        e.valid = 1'b1;
        e.access = !(r.op inside {LSAG_OP_SCALED, LSAG_OP_BITIDX, LSAG_OP_LINK});
        e.wb_en = r.op inside {LSAG_OP_PRE, LSAG_OP_POST, LSAG_OP_SCALED, LSAG_OP_BITIDX};
        e.wb_val = a;
        e.pair_wb_en = r.op inside {LSAG_OP_CIRC, LSAG_OP_BREV};
        e.pair_val = {r.pair[31:16], rev(rev(r.pair[15:0]) + rev(r.pair[31:16]))};
        case (r.op)
            LSAG_OP_ABS: a = {r.imm[17:14], 14'h0000, r.imm[13:0]};
            LSAG_OP_BLO: a = r.base + {{16{r.imm[15]}}, r.imm[15:0]};
            LSAG_OP_POST: a = r.base;
            LSAG_OP_BREV: a = r.base + ix;
            LSAG_OP_SCALED: e.wb_val = r.base + (r.data << r.scale);
            LSAG_OP_BITIDX: e.wb_val = (r.base + (r.data >> 3)) & 32'hffff_fffc;
            LSAG_OP_LINK: e.link_we = 1'b1;
            LSAG_OP_CIRC: begin
                a = r.base + ix;
                e.pair_val = {r.pair[31:16], raw[15:0]};
                e.split = (ix + nb) > ln;
                e.first_bytes = 4'(ln - ix);
                e.alignment_trap = r.base[2:0] != 3'h0 || ln % nb != 0 || ix >= ln;
            end
            default: ;
        endcase
        e.link_val = r.next_pc;
        e.addr = a;
        e.mem_trap = e.access && !(r.op inside {LSAG_OP_ABS, LSAG_OP_POST})
            && a[31:28] != r.base[31:28];
        if (e.alignment_trap || e.mem_trap) begin
            e.access = 1'b0;
            e.wb_en = 1'b0;
            e.pair_wb_en = 1'b0;
            e.split = 1'b0;
        end
        return e;
    endfunction

    // Present one request, capture the result pulse and compare it
    task automatic go(input lsag_op_e op, input logic [31:0] b, input logic [31:0] p,
            input logic [17:0] im, input logic [1:0] sz);
        lsag_req_s r;
        lsag_res_s e;
        r = '0;
        r.valid = 1'b1;
        r.op = op;
        r.base = b;
        r.pair = p;
        r.imm = im;
        r.size = lsag_size_e'(sz);
        r.data = $random(seed);
        r.scale = 2'($random(seed));
        r.next_pc = $random(seed);
        @(posedge sys_clk);
        req <= r;
        @(posedge sys_clk);
        req.valid <= 1'b0;
        @(negedge sys_clk);
        got = res;
        e = exp_of(r);
        check("flags", {24'h0, e.valid, e.access, e.wb_en, e.pair_wb_en, e.link_we,
            e.alignment_trap, e.mem_trap, e.split}, {24'h0, got.valid, got.access, got.wb_en,
            got.pair_wb_en, got.link_we, got.alignment_trap, got.mem_trap, got.split});
        if (e.access) check("addr", e.addr, got.addr);
        if (e.wb_en) check("wb_val", e.wb_val, got.wb_val);
        if (e.pair_wb_en) check("pair_val", e.pair_val, got.pair_val);
        if (e.link_we) check("link_val", e.link_val, got.link_val);
        if (e.split) check("first_bytes", {28'h0, e.first_bytes}, {28'h0, got.first_bytes});
        if (e.split) check("split_addr", b, got.split_addr);
    endtask

    // Watchdog
    initial begin
        #400000;
        error_cnt++;
        print_verdict;
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            check("brev_idx", {16'h0, idx_tbl[i]}, {16'h0, pair_q[15:0]});
            go(LSAG_OP_BREV, base_q, pair_q, 18'h0, 2'h1);
        end
        axi_rd(12'h000);
        check("ctrl", 32'h1, rd);
        axi_wr(12'h008, 32'h1234_5678);
        check("ro_resp", 32'h0, {30'h0, resp});
        axi_rd(12'h018);
        check("unmapped", 32'h2, {30'h0, resp});
        axi_wr(12'h000, 32'h0);
        exp_en = 1'b0;
        go(LSAG_OP_LINK, 32'h0, 32'h0, 18'h0, 2'h2);
        axi_wr(12'h000, 32'h1);
        exp_en = 1'b1;
        go(LSAG_OP_BSO, 32'h2fff_fffc, 32'h0, 18'h00008, 2'h2);
        go(LSAG_OP_PRE, 32'h3000_0000, 32'h0, 18'h003fc, 2'h2);
        go(LSAG_OP_ABS, 32'h0, 32'h0, 18'h3ffff, 2'h2);
        go(LSAG_OP_CIRC, 32'h1000, 32'h0032_0030, 18'h00002, 2'h1);
        go(LSAG_OP_CIRC, 32'h1000, 32'h0032_0030, 18'h00004, 2'h1);
        go(LSAG_OP_CIRC, 32'h1000, 32'h0032_0004, 18'h003f8, 2'h1);
        go(LSAG_OP_CIRC, 32'h1000, 32'h0034_0032, 18'h00002, 2'h2);
        go(LSAG_OP_CIRC, 32'h1004, 32'h0032_0000, 18'h0, 2'h1);
        go(LSAG_OP_CIRC, 32'h1000, 32'h0032_0000, 18'h0, 2'h2);
        go(LSAG_OP_CIRC, 32'h1000, 32'h0030_0030, 18'h0, 2'h3);
        // Counters after nine accesses and five traps
        axi_rd(12'h008);
        check("count", 32'h9, rd);
        axi_rd(12'h00c);
        check("last_addr", 32'h1032, rd);
        axi_rd(12'h010);
        check("trap_addr", 32'h1030, rd);
        axi_rd(12'h014);
        check("trap_count", 32'h5, rd);
        axi_rd(12'h004);
        check("status", 32'h3, rd);
        axi_wr(12'h004, 32'h3);
        axi_rd(12'h004);
        check("status_clr", 32'h0, rd);
        repeat (200) begin
            go(lsag_op_e'(4'({$random(seed)} % 10)), $random(seed) & 32'hf7ff_ffff,
                $random(seed) & 32'h00ff_00ff, 18'($random(seed)), 2'($random(seed)));
        end
        print_verdict;
    end
endmodule
